// ==== shared/audio_decoder_i2c_pkg.sv ====
// Constants, types and register map of the two-wire control port
// Operation
// - Data line changes only while clock low
// - Falling data, clock high, marks a start
// - Rising data, clock high, stop ends transfer
// - Transmitter releases; receiver acknowledges ninth pulse
// - Device samples data on rising clock edge
// - First byte MSB first, address 1000011
// - Last address bit one reads, zero writes
// - Matched address acknowledged; next byte is sub-address
// - Write acknowledges address and sub-address first
// - Single write: one data byte, then stop
// - Multibyte write fills successive registers until stop
// - Sub-address counter increments after every byte
// - Read returns register at current counter
// - Acknowledged read byte sends next register
// - Every register is one whole byte; here offsets 4D, 4E and 53 keep only 2, 1 and 4 bits
// - Registers load listed reset values
// - Registers without reset value are undefined; here writable ones reset to zero
// - Device is slave only, never drives clock
// - Read-only side data buffer of 56 bytes
package audio_decoder_i2c_pkg;

  // ----------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEVICE_ADDR = 7'h43;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] CHIP_ID = 8'h5A; // Arbitrary identification value

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHIP_VERSION = 8'h00;
  localparam logic [7:0] OFS_CHIP_IDENTIFIER = 8'h01;
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h05;
  localparam logic [7:0] OFS_REQUEST_POLARITY = 8'h0C;
  localparam logic [7:0] OFS_INPUT_CLOCK_POLARITY = 8'h0D;
  localparam logic [7:0] OFS_LAST_ERROR = 8'h0F;
  localparam logic [7:0] OFS_SOFTWARE_RESET_CMD = 8'h10;
  localparam logic [7:0] OFS_PLAYBACK_CONTROL = 8'h13;
  localparam logic [7:0] OFS_SILENCE_CONTROL = 8'h14;
  localparam logic [7:0] OFS_BUFFER_FILL_COMMAND = 8'h16;
  localparam logic [7:0] OFS_REQUEST_LINE_ENABLE = 8'h18;
  localparam logic [7:0] OFS_SYNC_STATE = 8'h40;
  localparam logic [7:0] OFS_SIDE_COUNT_LOW = 8'h41;
  localparam logic [7:0] OFS_SIDE_COUNT_HIGH = 8'h42;
  localparam logic [7:0] OFS_HEADER_HIGH = 8'h43;
  localparam logic [7:0] OFS_HEADER_MID = 8'h44;
  localparam logic [7:0] OFS_HEADER_LOW = 8'h45;
  localparam logic [7:0] OFS_OPERATING_FUNCTION = 8'h4D;
  localparam logic [7:0] OFS_CHECKSUM_ENABLE = 8'h4E;
  localparam logic [7:0] OFS_ENCODER_SAMPLE_RATE = 8'h53;
  localparam logic [7:0] OFS_SAMPLE_OUTPUT_CONFIG = 8'h55;
  localparam logic [7:0] OFS_FRAME_COUNTER_LOW = 8'h67;
  localparam logic [7:0] OFS_FRAME_COUNTER_MID = 8'h68;
  localparam logic [7:0] OFS_FRAME_COUNTER_HIGH = 8'h69;
  localparam logic [7:0] OFS_MEAN_BIT_RATE = 8'h6A;
  localparam logic [7:0] OFS_FIRMWARE_VERSION = 8'h71;
  localparam logic [7:0] OFS_DECODER_RUN_CMD = 8'h72;

  // Shared window and side data buffer
  localparam logic [7:0] ADPCM_FIRST = 8'h40;
  localparam logic [7:0] ADPCM_LAST = 8'h52;
  localparam int ADPCM_DEPTH = 19;
  localparam logic [7:0] SIDE_DATA_FIRST = 8'h7E;
  localparam logic [7:0] SIDE_DATA_LAST = 8'hB5;
  localparam int SIDE_DATA_DEPTH = 56;
  localparam logic [1:0] FUNC_DECODE = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX = 6'h04,
    ST_ACK = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } link_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } line_events_s;

  typedef struct packed {
    logic [7:0] chip_version;
    logic [7:0] last_error;
    logic [7:0] sync_state;
    logic [15:0] side_count;
    logic [23:0] frame_header;
    logic [23:0] frame_counter;
    logic [7:0] mean_bit_rate;
    logic [7:0] firmware_version;
  } decoder_status_s;

  typedef struct packed {
    logic [7:0] clock_control;
    logic [7:0] request_polarity;
    logic [7:0] input_clock_polarity;
    logic [7:0] playback_control;
    logic [7:0] silence_control;
    logic [7:0] buffer_fill_command;
    logic [7:0] request_line_enable;
    logic [7:0] operating_function;
    logic [7:0] sample_output_config;
    logic [7:0] decoder_run_cmd;
    logic soft_reset;
  } decoder_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

  // ----------------------------------------------------------------
  // Map decoding
  // ----------------------------------------------------------------
  // Writable plain registers outside the shared window semantics
  function automatic logic reg_writable(input logic [7:0] a);
    case (a)
      8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h13, 8'h14, 8'h16, 8'h18,
      8'h46, 8'h47, 8'h48, 8'h49, 8'h4D, 8'h4E, 8'h50, 8'h51, 8'h52,
      8'h53, 8'h54, 8'h55, 8'h56, 8'h61, 8'h63, 8'h64, 8'h65, 8'h72,
      8'h77, 8'h78, 8'h79, 8'h7A, 8'h7B: reg_writable = 1'b1;
      default: reg_writable = 1'b0;
    endcase
  endfunction

  // Listed reset values; unlisted writable ones clear to zero
  function automatic logic [7:0] reg_reset(input logic [7:0] a);
    case (a)
      8'h05: reg_reset = 8'hA1;
      8'h06: reg_reset = 8'h0C;
      8'h0C: reg_reset = 8'h01;
      8'h0D: reg_reset = 8'h04;
      8'h13: reg_reset = 8'h01;
      8'h47, 8'h49: reg_reset = 8'hFF;
      8'h54: reg_reset = 8'h03;
      8'h55: reg_reset = 8'h21;
      8'h61: reg_reset = 8'h07;
      8'h64: reg_reset = 8'h46;
      8'h65: reg_reset = 8'h5B;
      default: reg_reset = 8'h00;
    endcase
  endfunction

  // Useful width of narrow registers
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    case (a)
      OFS_OPERATING_FUNCTION: reg_mask = 8'h03;
      OFS_CHECKSUM_ENABLE: reg_mask = 8'h01;
      OFS_ENCODER_SAMPLE_RATE: reg_mask = 8'h0F;
      default: reg_mask = 8'hFF;
    endcase
  endfunction

endpackage

// ==== hw/i2c_line_events.sv ====
// Start, stop and clock edge detection on the two bus lines
`timescale 1ns/100ps
module i2c_line_events (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Events
  output audio_decoder_i2c_pkg::line_events_s ev_o
);

  logic scl_q, scl_d;
  logic sda_q, sda_d;

  // Previous line levels; idle bus reads high
  always_comb
  begin
    scl_d = scl_i;
    sda_d = sda_i;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // Data edges with clock held high are framing, not data
  assign ev_o.start = scl_q & scl_i & sda_q & ~sda_i;
  assign ev_o.stop = scl_q & scl_i & ~sda_q & sda_i;
  assign ev_o.rise = ~scl_q & scl_i;
  assign ev_o.fall = scl_q & ~scl_i;
  assign ev_o.sda = sda_i;

endmodule // i2c_line_events

// ==== hw/audio_decoder_i2c_slave_regs.sv ====
// Two-wire slave port and control register file of the audio decoder
`timescale 1ns/100ps
module audio_decoder_i2c_slave_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Bus pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Decoder core status and side data
  input wire audio_decoder_i2c_pkg::decoder_status_s status_i,
  input wire logic [audio_decoder_i2c_pkg::SIDE_DATA_DEPTH-1:0][7:0] side_data_i,
  // Decoder core control
  output audio_decoder_i2c_pkg::decoder_ctrl_s ctrl_o,
  output audio_decoder_i2c_pkg::reg_write_s wr_evt_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  audio_decoder_i2c_pkg::line_events_s ev;
  audio_decoder_i2c_pkg::link_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] sub_q, sub_d;
  logic first_q, first_d;
  logic rd_q, rd_d;
  logic oe_q, oe_d;
  logic ack_q, ack_d;
  logic soft_q, soft_d;
  audio_decoder_i2c_pkg::reg_write_s wr_q, wr_d;
  logic [7:0] rd_byte;
  logic [7:0] regs_q [0:255];
  logic [7:0] regs_d [0:255];
  logic [7:0] adpcm_q [0:audio_decoder_i2c_pkg::ADPCM_DEPTH-1];
  logic [7:0] adpcm_d [0:audio_decoder_i2c_pkg::ADPCM_DEPTH-1];

  // ----------------------------------------------------------------
  // Map helpers
  // ----------------------------------------------------------------
  // Shared window reads as encoder data only outside decode function;
  // the function register itself stays reachable so the mode can be left
  function automatic logic adpcm_sel(input logic [7:0] a, input logic [7:0] func);
    adpcm_sel = (func[1:0] != audio_decoder_i2c_pkg::FUNC_DECODE) &&
                (a != audio_decoder_i2c_pkg::OFS_OPERATING_FUNCTION) &&
                (a >= audio_decoder_i2c_pkg::ADPCM_FIRST) && (a <= audio_decoder_i2c_pkg::ADPCM_LAST);
  endfunction

  function automatic logic [4:0] adpcm_idx(input logic [7:0] a);
    logic [7:0] diff;
    diff = a - audio_decoder_i2c_pkg::ADPCM_FIRST;
    adpcm_idx = diff[4:0];
  endfunction

  // ----------------------------------------------------------------
  // Line event detection
  // ----------------------------------------------------------------
  i2c_line_events u_events (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev_o(ev)
  );

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Status fields come live from the core, no snapshot is taken
  always_comb
  begin
    logic [7:0] sd_off;
    sd_off = sub_q - audio_decoder_i2c_pkg::SIDE_DATA_FIRST;
    rd_byte = 8'h00;
    if (adpcm_sel(sub_q, regs_q[audio_decoder_i2c_pkg::OFS_OPERATING_FUNCTION]))
    begin
      rd_byte = adpcm_q[adpcm_idx(sub_q)];
    end
    else if (sub_q >= audio_decoder_i2c_pkg::SIDE_DATA_FIRST && sub_q <= audio_decoder_i2c_pkg::SIDE_DATA_LAST)
    begin
      rd_byte = side_data_i[sd_off[5:0]];
    end
    else
    begin
      case (sub_q)
        audio_decoder_i2c_pkg::OFS_CHIP_VERSION: rd_byte = status_i.chip_version;
        audio_decoder_i2c_pkg::OFS_CHIP_IDENTIFIER: rd_byte = audio_decoder_i2c_pkg::CHIP_ID;
        audio_decoder_i2c_pkg::OFS_LAST_ERROR: rd_byte = status_i.last_error;
        audio_decoder_i2c_pkg::OFS_SYNC_STATE: rd_byte = status_i.sync_state;
        audio_decoder_i2c_pkg::OFS_SIDE_COUNT_LOW: rd_byte = status_i.side_count[7:0];
        audio_decoder_i2c_pkg::OFS_SIDE_COUNT_HIGH: rd_byte = status_i.side_count[15:8];
        audio_decoder_i2c_pkg::OFS_HEADER_HIGH: rd_byte = status_i.frame_header[23:16];
        audio_decoder_i2c_pkg::OFS_HEADER_MID: rd_byte = status_i.frame_header[15:8];
        audio_decoder_i2c_pkg::OFS_HEADER_LOW: rd_byte = status_i.frame_header[7:0];
        audio_decoder_i2c_pkg::OFS_FRAME_COUNTER_LOW: rd_byte = status_i.frame_counter[7:0];
        audio_decoder_i2c_pkg::OFS_FRAME_COUNTER_MID: rd_byte = status_i.frame_counter[15:8];
        audio_decoder_i2c_pkg::OFS_FRAME_COUNTER_HIGH: rd_byte = status_i.frame_counter[23:16];
        audio_decoder_i2c_pkg::OFS_MEAN_BIT_RATE: rd_byte = status_i.mean_bit_rate;
        audio_decoder_i2c_pkg::OFS_FIRMWARE_VERSION: rd_byte = status_i.firmware_version;
        default:
        begin
          // Reserved offsets read as zero; writable ones read back their stored value
          if (audio_decoder_i2c_pkg::reg_writable(sub_q))
          begin
            rd_byte = regs_q[sub_q];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus protocol state machine
  // ----------------------------------------------------------------
  // All line changes are made on a falling clock, so data never moves while clock is high
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    sub_d = sub_q;
    first_d = first_q;
    rd_d = rd_q;
    oe_d = oe_q;
    ack_d = ack_q;
    soft_d = 1'b0;
    wr_d = '0;
    if (ev.stop)
    begin
      state_d = audio_decoder_i2c_pkg::ST_IDLE;
      oe_d = 1'b0;
    end
    else if (ev.start)
    begin
      state_d = audio_decoder_i2c_pkg::ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
      first_d = 1'b1;
    end
    else
    begin
      case (state_q)
        audio_decoder_i2c_pkg::ST_IDLE:
        begin
          oe_d = 1'b0;
        end
        audio_decoder_i2c_pkg::ST_ADDR, audio_decoder_i2c_pkg::ST_RX:
        begin
          if (ev.rise && cnt_q != audio_decoder_i2c_pkg::BITS_PER_BYTE)
          begin
            shift_d = {shift_q[6:0], ev.sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (ev.fall && cnt_q == audio_decoder_i2c_pkg::BITS_PER_BYTE)
          begin
            if (state_q == audio_decoder_i2c_pkg::ST_ADDR)
            begin
              if (shift_q[7:1] == audio_decoder_i2c_pkg::DEVICE_ADDR)
              begin
                rd_d = shift_q[0];
                oe_d = 1'b1;
                state_d = audio_decoder_i2c_pkg::ST_ACK;
              end
              else
              begin
                state_d = audio_decoder_i2c_pkg::ST_IDLE;
              end
            end
            else
            begin
              oe_d = 1'b1;
              state_d = audio_decoder_i2c_pkg::ST_ACK;
              if (first_q)
              begin
                sub_d = shift_q;
                first_d = 1'b0;
              end
              else
              begin
                wr_d.valid = 1'b1;
                wr_d.addr = sub_q;
                wr_d.data = shift_q;
                soft_d = (sub_q == audio_decoder_i2c_pkg::OFS_SOFTWARE_RESET_CMD);
                sub_d = sub_q + 8'h01;
              end
            end
          end
        end
        audio_decoder_i2c_pkg::ST_ACK:
        begin
          if (ev.fall)
          begin
            cnt_d = 4'h0;
            if (rd_q)
            begin
              state_d = audio_decoder_i2c_pkg::ST_TX;
              shift_d = rd_byte;
              oe_d = ~rd_byte[7];
            end
            else
            begin
              state_d = audio_decoder_i2c_pkg::ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        audio_decoder_i2c_pkg::ST_TX:
        begin
          if (ev.rise)
          begin
            cnt_d = cnt_q + 4'h1;
          end
          else if (ev.fall)
          begin
            if (cnt_q == audio_decoder_i2c_pkg::BITS_PER_BYTE)
            begin
              oe_d = 1'b0;
              state_d = audio_decoder_i2c_pkg::ST_MACK;
              sub_d = sub_q + 8'h01;
            end
            else
            begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d = ~shift_q[6];
            end
          end
        end
        audio_decoder_i2c_pkg::ST_MACK:
        begin
          if (ev.rise)
          begin
            ack_d = ~ev.sda;
          end
          else if (ev.fall)
          begin
            if (ack_q)
            begin
              state_d = audio_decoder_i2c_pkg::ST_TX;
              cnt_d = 4'h0;
              shift_d = rd_byte;
              oe_d = ~rd_byte[7];
            end
            else
            begin
              state_d = audio_decoder_i2c_pkg::ST_IDLE;
            end
          end
        end
        default:
        begin
          state_d = audio_decoder_i2c_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= audio_decoder_i2c_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      first_q <= 1'b1;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      ack_q <= 1'b0;
      soft_q <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      sub_q <= sub_d;
      first_q <= first_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      ack_q <= ack_d;
      soft_q <= soft_d;
      wr_q <= wr_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes to read-only or reserved offsets are dropped silently
  always_comb
  begin
    regs_d = regs_q;
    adpcm_d = adpcm_q;
    if (wr_d.valid)
    begin
      if (adpcm_sel(wr_d.addr, regs_q[audio_decoder_i2c_pkg::OFS_OPERATING_FUNCTION]))
      begin
        adpcm_d[adpcm_idx(wr_d.addr)] = wr_d.data;
      end
      else if (audio_decoder_i2c_pkg::reg_writable(wr_d.addr))
      begin
        regs_d[wr_d.addr] = wr_d.data & audio_decoder_i2c_pkg::reg_mask(wr_d.addr);
      end
    end
  end

  // Only writable offsets get flops; the rest are constant zero
  for (genvar g = 0; g < 256; g++)
  begin : g_regs
    if (audio_decoder_i2c_pkg::reg_writable(8'(g)))
    begin : g_rw
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          regs_q[g] <= audio_decoder_i2c_pkg::reg_reset(8'(g));
        end
        else
        begin
          regs_q[g] <= regs_d[g];
        end
      end
    end
    else
    begin : g_none
      assign regs_q[g] = 8'h00;
    end
  end

  // Encoder data words share offsets with decoder status
  for (genvar k = 0; k < audio_decoder_i2c_pkg::ADPCM_DEPTH; k++)
  begin : g_adpcm
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        adpcm_q[k] <= 8'h00;
      end
      else
      begin
        adpcm_q[k] <= adpcm_d[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pull low, clock is never driven
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign wr_evt_o = wr_q;
  assign ctrl_o.clock_control = regs_q[audio_decoder_i2c_pkg::OFS_CLOCK_CONTROL];
  assign ctrl_o.request_polarity = regs_q[audio_decoder_i2c_pkg::OFS_REQUEST_POLARITY];
  assign ctrl_o.input_clock_polarity = regs_q[audio_decoder_i2c_pkg::OFS_INPUT_CLOCK_POLARITY];
  assign ctrl_o.playback_control = regs_q[audio_decoder_i2c_pkg::OFS_PLAYBACK_CONTROL];
  assign ctrl_o.silence_control = regs_q[audio_decoder_i2c_pkg::OFS_SILENCE_CONTROL];
  assign ctrl_o.buffer_fill_command = regs_q[audio_decoder_i2c_pkg::OFS_BUFFER_FILL_COMMAND];
  assign ctrl_o.request_line_enable = regs_q[audio_decoder_i2c_pkg::OFS_REQUEST_LINE_ENABLE];
  assign ctrl_o.operating_function = regs_q[audio_decoder_i2c_pkg::OFS_OPERATING_FUNCTION];
  assign ctrl_o.sample_output_config = regs_q[audio_decoder_i2c_pkg::OFS_SAMPLE_OUTPUT_CONFIG];
  assign ctrl_o.decoder_run_cmd = regs_q[audio_decoder_i2c_pkg::OFS_DECODER_RUN_CMD];
  assign ctrl_o.soft_reset = soft_q;

endmodule // audio_decoder_i2c_slave_regs

// ==== verif/bus_master_model.sv ====
// Behavioural two-wire bus master
`timescale 1ns/100ps
module bus_master_model (
  // Clock
  input wire logic core_clk_i,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Idle bus: both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One bus phase of four core cycles, so each level spans four samples
  task automatic phase();
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
  // Start condition
  task automatic start();
    sda_low_o = 1'b0;
    phase();
    scl_o = 1'b1;
    phase();
    sda_low_o = 1'b1;
    phase();
    scl_o = 1'b0;
  endtask
  // Stop condition
  task automatic stop();
    sda_low_o = 1'b1;
    phase();
    scl_o = 1'b1;
    phase();
    sda_low_o = 1'b0;
    phase();
  endtask
  // Eight bits MSB first, then the acknowledge slot; sda moves only with scl low
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    logic [8:0] b;
    logic [8:0] s;
    b = {tx, ack_in};
    for (int i = 8; i >= 0; i--)
    begin
      sda_low_o = ~b[i];
      phase();
      scl_o = 1'b1;
      phase();
      s[i] = sda_i;
      scl_o = 1'b0;
    end
    {rx, ack_out} = s;
  endtask
endmodule // bus_master_model

// ==== verif/audio_decoder_i2c_monitor.sv ====
// Checker of the two-wire port outputs
`timescale 1ns/100ps
module audio_decoder_i2c_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Core side
  input wire audio_decoder_i2c_pkg::decoder_status_s status_i,
  input wire logic [audio_decoder_i2c_pkg::SIDE_DATA_DEPTH-1:0][7:0] side_data_i,
  input wire audio_decoder_i2c_pkg::decoder_ctrl_s ctrl_o,
  input wire audio_decoder_i2c_pkg::reg_write_s wr_evt_o
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Pin relations; reset check stays live while reset is low
  a_drain_low: assert property (sda_o == 1'b0)
    else $error("sda_o high");
  a_oe_clock_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("sda moved with scl high");
  a_start_quiet: assert property (scl_i && $past(scl_i) && $fell(sda_i) |=> !sda_oe_o [*8])
    else $error("drive after start");
  a_stop_release: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:2] !sda_oe_o)
    else $error("drive after stop");
  a_ack_with_write: assert property (wr_evt_o.valid |-> sda_oe_o && !scl_i)
    else $error("write without ack");
  a_write_pulse: assert property (wr_evt_o.valid |=> !wr_evt_o.valid)
    else $error("write pulse long");
  a_soft_reset_cause: assert property (ctrl_o.soft_reset |-> wr_evt_o.valid && wr_evt_o.addr == 8'h10)
    else $error("stray soft reset");
  a_soft_reset_fire: assert property (wr_evt_o.valid && wr_evt_o.addr == 8'h10 |-> ctrl_o.soft_reset)
    else $error("soft reset missing");
  a_play_by_write: assert property ($changed(ctrl_o.playback_control) |->
    (wr_evt_o.valid && wr_evt_o.addr == 8'h13 && wr_evt_o.data == ctrl_o.playback_control) ||
    ($past(wr_evt_o.valid) && $past(wr_evt_o.addr) == 8'h13 && $past(wr_evt_o.data) == ctrl_o.playback_control))
    else $error("play changed without write");
  a_reset_values: assert property (disable iff (1'b0) !resetn_i |-> ctrl_o.clock_control == 8'hA1 &&
    ctrl_o.sample_output_config == 8'h21 && !sda_oe_o && !wr_evt_o.valid)
    else $error("reset value wrong");
endmodule // audio_decoder_i2c_monitor

// ==== verif/testbench.sv ====
// Self-checking bench of the two-wire slave port
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b1;
  logic scl, sda_low, sda_o, sda_oe_o, ack;
  wire sda;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] lfsr = 32'h263C;
  logic [127:0] rbits;
  logic [7:0] rx, d0, d1;
  logic [7:0] none[$];
  logic [7:0] q[$];
  logic [6:0] bad[3] = '{7'h42, 7'h03, 7'h63};
  audio_decoder_i2c_pkg::decoder_status_s status_i;
  logic [audio_decoder_i2c_pkg::SIDE_DATA_DEPTH-1:0][7:0] side_data_i;
  audio_decoder_i2c_pkg::decoder_ctrl_s ctrl_o;
  audio_decoder_i2c_pkg::reg_write_s wr_evt_o;
  // Clock and wired-and data line with pull-up
  always #12.5 core_clk_i = ~core_clk_i;
  assign sda = ~(sda_low | sda_oe_o);
  audio_decoder_i2c_slave_regs audio_decoder_i2c_slave_regs_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .status_i(status_i), .side_data_i(side_data_i),
    .ctrl_o(ctrl_o), .wr_evt_o(wr_evt_o));
  bus_master_model bus_master_model_inst (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // Stimulus shift register and expected reset values
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h05: return 8'hA1;
      8'h0C, 8'h13: return 8'h01;
      8'h0D: return 8'h04;
      8'h54: return 8'h03;
      8'h55: return 8'h21;
      default: return 8'h00;
    endcase
  endfunction
  // Write transfer: address, sub-address, data bytes
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    bus_master_model_inst.start();
    bus_master_model_inst.byte_io({audio_decoder_i2c_pkg::DEVICE_ADDR, 1'b0}, 1'b1, rx, ack);
    `CHK("addr ack", 1'b0, ack)
    bus_master_model_inst.byte_io(sub, 1'b1, rx, ack);
    `CHK("sub ack", 1'b0, ack)
    foreach (d[i])
    begin
      bus_master_model_inst.byte_io(d[i], 1'b1, rx, ack);
      `CHK("data ack", 1'b0, ack)
    end
    bus_master_model_inst.stop();
  endtask
  // Point the counter, then read a run, nack on the last byte
  task automatic rd(input logic [7:0] sub, input logic [7:0] e[$]);
    wr(sub, none);
    bus_master_model_inst.start();
    bus_master_model_inst.byte_io({audio_decoder_i2c_pkg::DEVICE_ADDR, 1'b1}, 1'b1, rx, ack);
    `CHK("read ack", 1'b0, ack)
    foreach (e[i])
    begin
      bus_master_model_inst.byte_io(8'hFF, i == e.size() - 1, rx, ack);
      `CHK("read data", e[i], rx)
    end
    bus_master_model_inst.stop();
  endtask
  // Closing report
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog at roughly four times the expected run
  initial
  begin
    #1000000;
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    rbits = {rnd(), rnd(), rnd(), rnd()};
    status_i = rbits[103:0];
    foreach (side_data_i[i])
      side_data_i[i] = 8'(rnd());
    // Real falling edge, so every flop takes its reset value before the first clock
    #1 resetn_i = 1'b0;
    repeat (10) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    `CHK("clock reset", rst_val(8'h05), ctrl_o.clock_control)
    `CHK("config reset", rst_val(8'h55), ctrl_o.sample_output_config)
    rd(8'h00, {status_i.chip_version, audio_decoder_i2c_pkg::CHIP_ID});
    rd(8'h0C, {rst_val(8'h0C), rst_val(8'h0D)});
    rd(8'h0F, {status_i.last_error});
    rd(8'h54, {rst_val(8'h54), rst_val(8'h55), 8'h00});
    foreach (bad[i])
    begin
      bus_master_model_inst.start();
      bus_master_model_inst.byte_io({bad[i], 1'b0}, 1'b1, rx, ack);
      `CHK("foreign ack", 1'b1, ack)
      bus_master_model_inst.stop();
    end
    d0 = 8'(rnd());
    d1 = 8'(rnd());
    wr(8'h13, {d0, d1});
    `CHK("play", d0, ctrl_o.playback_control)
    `CHK("silence", d1, ctrl_o.silence_control)
    rd(8'h13, {d0, d1});
    wr(8'h10, {8'h01});
    rd(8'h40, {status_i.sync_state, status_i.side_count[7:0]});
    wr(8'h4D, {8'hFD});
    `CHK("function", 8'h01, ctrl_o.operating_function)
    rd(8'h4D, {8'h01});
    wr(8'h40, {d1});
    rd(8'h40, {d1});
    wr(8'h4D, {8'h00});
    rd(8'h40, {status_i.sync_state});
    foreach (side_data_i[i])
      q.push_front(side_data_i[i]); // Loop runs from index 55 down to 0
    rd(8'h7E, q);
    print_verdict();
  end
endmodule // testbench
bind audio_decoder_i2c_slave_regs audio_decoder_i2c_monitor audio_decoder_i2c_monitor_inst (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .status_i(status_i),
  .side_data_i(side_data_i), .ctrl_o(ctrl_o), .wr_evt_o(wr_evt_o));
